// ---- sacs_core.sv ----
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Result left or right justified by format
// - Converter runs only while enable is set
// - Zero acquisition converts directly, else delay first
// - Zero acquisition start waits one instruction
// - Code 010 gives four period acquisition
// - Completion clears go, flags, stores result
// - Capacitor array discharged after every sample
// - Abort stores partial, fills with last bit
// - Reset clears registers, stops converter
// - Two periods wait, then sampling resumes
// - RC clock adds one instruction before start
// - Sleep completion wakes or powers down
// - Sleep without RC clock aborts, powers down
// - Special event sets go, resets timer
// - Control 0 holds channel, go, enable
// - Channel codes select inputs, DAC, reference
// - Go reads one while converting
// - Positive reference select decode
// - Negative reference select decode
// - Acquisition code table in conversion periods
// - Conversion clock divider table, RC codes
// - Full conversion takes eleven periods
// - Justified byte layouts of result
module sacs_core
  import sacs_pkg::*;
#(
  parameter int INSTR_CYCLES = sacs_pkg::INSTR_CLKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [sacs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // System side
  input wire logic sleep_mode,
  input wire logic converter_interrupt_enable,
  input wire logic special_event,
  output logic converter_interrupt_flag,
  output logic wake_request,
  output logic timer_counter_reset,
  // Analog side
  input wire logic rc_clk_pin,
  input wire logic comparator_pin,
  output logic analog_power,
  output logic sample_connect,
  output logic array_discharge,
  output logic [9:0] sar_trial,
  output logic [3:0] channel_select_field,
  output logic channel_valid,
  output logic pref_ext_sel,
  output logic pref_fvr_sel,
  output logic nref_ext_sel
);
  import sacs_pkg::*;

  typedef struct packed {
    sacs_state_t state;
    logic [3:0] chs;
    logic go;
    logic en;
    logic fmt;
    logic [2:0] acqt;
    logic [2:0] adcs;
    logic [1:0] pref;
    logic [1:0] nref;
    logic flag;
    logic off;
    logic [9:0] res;
    logic [9:0] acc;
    logic [9:0] trial;
    logic [3:0] bitn;
    logic [4:0] tads;
    logic [5:0] div;
    logic [7:0] hold;
    logic [2:0] rc_s;
    logic rc_f;
    logic [2:0] cmp_s;
    logic cmp_f;
    logic [7:0] rdata;
    logic wake;
    logic tmr_rst;
  } sacs_regs_t;

  sacs_regs_t r;
  sacs_regs_t next_r;

  logic is_rc;
  logic tad_tick;
  logic rc_rise;
  logic start_req;
  logic abort_req;
  logic sleep_kill;
  logic busy;
  logic [3:0] k;
  logic last_bit;
  logic [9:0] part;
  logic [7:0] resh;
  logic [7:0] resl;
  logic wr_ctrl0;

  // Conversion clock source decode
  // RC codes end 11
  assign is_rc = (r.adcs[1:0] == ADCS_RC_LOW);
  // Filtered RC edge, counted only when the last two sync stages agree
  assign rc_rise = r.rc_s[1] & r.rc_s[2] & ~r.rc_f;
  assign tad_tick = is_rc ? rc_rise : (r.div == sacs_div_last(r.adcs));

  assign busy = (r.state == ST_HOLDOFF) || (r.state == ST_ACQ) || (r.state == ST_CONV);
  assign wr_ctrl0 = reg_wr && (reg_addr == OFF_CTRL0);

  assign start_req = r.en && !r.off && (r.state == ST_SAMPLE)
                     && ((wr_ctrl0 && reg_wdata[CTRL0_GO]) || special_event);
  assign abort_req = busy && wr_ctrl0 && !reg_wdata[CTRL0_GO] && reg_wdata[CTRL0_EN];
  assign sleep_kill = sleep_mode && !is_rc && busy;

  // partial result filled with last converted bit
  assign k = r.bitn;
  always_comb begin
    last_bit = 1'b0;
    if (k >= 4'h2) begin
      last_bit = r.acc[4'(4'd11 - k)];
    end
    part = r.acc;
    for (int i = 0; i < 10; i++) begin
      if (i < 11 - int'(k)) begin
        part[i] = last_bit;
      end
    end
  end

  always_comb begin
    if (r.fmt) begin
      resh = {6'h00, r.res[9:8]};
      resl = r.res[7:0];
    end else begin
      resh = r.res[9:2];
      resl = {r.res[1:0], 6'h00};
    end
  end

  // Next state of the whole block
  always_comb begin
    next_r = r;
    next_r.wake = 1'b0;
    next_r.tmr_rst = 1'b0;
    next_r.rdata = RST_BYTE;

    // Three-stage input synchronisers
    next_r.rc_s = {r.rc_s[1:0], rc_clk_pin};
    next_r.cmp_s = {r.cmp_s[1:0], comparator_pin};
    if (r.rc_s[1] == r.rc_s[2]) begin
      next_r.rc_f = r.rc_s[2];
    end
    if (r.cmp_s[1] == r.cmp_s[2]) begin
      next_r.cmp_f = r.cmp_s[2];
    end

    // Divider runs only while enabled, restarts on each tick
    if (!r.en || tad_tick || is_rc) begin
      next_r.div = 6'h00;
    end else begin
      next_r.div = r.div + 6'h01;
    end

    // Read data one cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        // control 0 layout, top bits zero
        OFF_CTRL0: next_r.rdata = {2'h0, r.chs, r.go, r.en};
        OFF_CTRL1: next_r.rdata = {4'h0, r.pref, r.nref};
        OFF_CTRL2: next_r.rdata = {r.fmt, 1'b0, r.acqt, r.adcs};
        OFF_RESH: next_r.rdata = resh;
        OFF_RESL: next_r.rdata = resl;
        OFF_STAT: next_r.rdata = {6'h00, r.off, r.flag};
        default: next_r.rdata = RST_BYTE;
      endcase
    end

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        OFF_CTRL0: begin
          next_r.chs = reg_wdata[CTRL0_CHS +: 4];
          next_r.en = reg_wdata[CTRL0_EN];
        end
        OFF_CTRL1: begin
          next_r.pref = reg_wdata[CTRL1_PREF +: 2];
          next_r.nref = reg_wdata[CTRL1_NREF +: 2];
        end
        OFF_CTRL2: begin
          next_r.fmt = reg_wdata[CTRL2_FMT];
          next_r.acqt = reg_wdata[CTRL2_ACQT +: 3];
          next_r.adcs = reg_wdata[CTRL2_ADCS +: 3];
        end
        OFF_STAT: begin
          if (reg_wdata[STAT_FLAG]) begin
            next_r.flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Power-down after sleep ends when the system wakes
    if (!sleep_mode) begin
      next_r.off = 1'b0;
    end

    // Sequencer
    case (r.state)
      ST_OFF: begin
        if (r.en) begin
          next_r.state = ST_SAMPLE;
        end
      end
      ST_SAMPLE: begin
        if (start_req) begin
          next_r.go = 1'b1;
          next_r.tmr_rst = special_event;
          next_r.hold = is_rc ? 8'(2 * INSTR_CYCLES - 1) : 8'(INSTR_CYCLES - 1);
          next_r.state = ST_HOLDOFF;
        end
      end
      ST_HOLDOFF: begin
        if (r.hold != 8'h00) begin
          next_r.hold = r.hold - 8'h01;
        end else if (sacs_acq_tads(r.acqt) == 5'h00) begin
          // direct start when acquisition is zero
          next_r.state = ST_CONV;
          next_r.bitn = 4'h0;
          next_r.acc = RST_RES;
          next_r.trial = RST_RES;
        end else begin
          next_r.tads = sacs_acq_tads(r.acqt);
          next_r.state = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (tad_tick) begin
          next_r.tads = r.tads - 5'h01;
          if (r.tads == 5'h01) begin
            next_r.state = ST_CONV;
            next_r.bitn = 4'h0;
            next_r.acc = RST_RES;
            next_r.trial = RST_RES;
          end
        end
      end
      ST_CONV: begin
        // one setup period then ten bit periods
        if (tad_tick) begin
          next_r.bitn = r.bitn + 4'h1;
          if (r.bitn != 4'h0) begin
            next_r.acc[4'(CONV_LAST_TAD - r.bitn)] = r.cmp_f;
          end
          if (r.bitn == CONV_LAST_TAD) begin
            next_r.res = {r.acc[9:1], r.cmp_f};
            next_r.go = 1'b0;
            next_r.flag = 1'b1;
            next_r.trial = RST_RES;
            next_r.tads = WAIT_TADS;
            next_r.state = ST_WAIT;
            // sleep completion wakes or powers down
            if (sleep_mode) begin
              if (converter_interrupt_enable) begin
                next_r.wake = 1'b1;
              end else begin
                next_r.off = 1'b1;
              end
            end
          end else begin
            next_r.trial = next_r.acc;
            next_r.trial[4'(4'h9 - r.bitn)] = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (tad_tick) begin
          next_r.tads = r.tads - 5'h01;
          if (r.tads == 5'h01) begin
            next_r.state = ST_SAMPLE;
          end
        end
      end
      default: next_r.state = ST_OFF;
    endcase

    if (abort_req) begin
      next_r.go = 1'b0;
      next_r.trial = RST_RES;
      next_r.tads = WAIT_TADS;
      next_r.state = ST_WAIT;
      if (r.state == ST_CONV) begin
        next_r.res = part;
      end
    end

    // abort and power down, enable kept
    if (sleep_kill) begin
      next_r.go = 1'b0;
      next_r.off = 1'b1;
      next_r.trial = RST_RES;
      next_r.state = ST_WAIT;
      next_r.tads = WAIT_TADS;
    end

    if ((wr_ctrl0 && !reg_wdata[CTRL0_EN]) || !r.en) begin
      next_r.go = 1'b0;
      next_r.trial = RST_RES;
      if (!(r.state == ST_OFF && r.en)) begin
        next_r.state = ST_OFF;
      end
    end

    // Set beats a software clear in the same cycle
    if (next_r.state == ST_WAIT && r.state == ST_CONV && tad_tick && r.bitn == CONV_LAST_TAD) begin
      next_r.flag = 1'b1;
    end
  end

  // reset returns all registers, converter off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // Register-side outputs
  assign reg_rdata = r.rdata;
  assign converter_interrupt_flag = r.flag;
  assign wake_request = r.wake;
  assign timer_counter_reset = r.tmr_rst;

  assign analog_power = r.en && !r.off;
  // array discharged during setup period and wait
  assign array_discharge = analog_power
                           && ((r.state == ST_WAIT) || (r.state == ST_CONV && r.bitn == 4'h0));
  // Hold capacitor follows the channel while sampling
  assign sample_connect = analog_power
                          && ((r.state == ST_SAMPLE) || (r.state == ST_HOLDOFF) || (r.state == ST_ACQ));
  assign sar_trial = r.trial;

  assign channel_select_field = r.chs;
  assign channel_valid = ((r.chs >= CHS_FIRST_AN) && (r.chs <= CHS_LAST_AN))
                         || (r.chs == CHS_DAC) || (r.chs == CHS_FVR);
  assign pref_ext_sel = (r.pref == PREF_EXT);
  assign pref_fvr_sel = (r.pref == PREF_FVR);
  assign nref_ext_sel = (r.nref == NREF_EXT);

endmodule

// ---- sacs_pkg.sv ----
package sacs_pkg;

  // Register index on the plain register port
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFF_CTRL0 = 3'h0;
  localparam logic [2:0] OFF_CTRL1 = 3'h1;
  localparam logic [2:0] OFF_CTRL2 = 3'h2;
  localparam logic [2:0] OFF_RESH = 3'h3;
  localparam logic [2:0] OFF_RESL = 3'h4;
  localparam logic [2:0] OFF_STAT = 3'h5;

  // Field positions
  localparam int CTRL0_EN = 0;
  localparam int CTRL0_GO = 1;
  localparam int CTRL0_CHS = 2;
  localparam int CTRL1_NREF = 0;
  localparam int CTRL1_PREF = 2;
  localparam int CTRL2_ADCS = 0;
  localparam int CTRL2_ACQT = 3;
  localparam int CTRL2_FMT = 7;
  localparam int STAT_FLAG = 0;
  localparam int STAT_OFF = 1;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [9:0] RST_RES = 10'h000;

  // Channel codes
  localparam logic [3:0] CHS_FIRST_AN = 4'h3;
  localparam logic [3:0] CHS_LAST_AN = 4'hb;
  localparam logic [3:0] CHS_DAC = 4'he;
  localparam logic [3:0] CHS_FVR = 4'hf;

  // Reference codes
  localparam logic [1:0] PREF_EXT = 2'h1;
  localparam logic [1:0] PREF_FVR = 2'h2;
  localparam logic [1:0] NREF_EXT = 2'h1;

  // Conversion clock codes that pick the internal RC clock end in 11
  localparam logic [1:0] ADCS_RC_LOW = 2'h3;

  // Timing in conversion clock periods
  localparam logic [3:0] CONV_LAST_TAD = 4'ha;
  localparam logic [4:0] WAIT_TADS = 5'h02;

  // Clock: 10 MHz, instruction cycle of four clocks
  localparam int CLK_PERIOD_NS = 100;
  localparam int INSTR_NS = 400;
  localparam int INSTR_CLKS = (INSTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_OFF, ST_SAMPLE, ST_HOLDOFF, ST_ACQ, ST_CONV, ST_WAIT
  } sacs_state_t;

  // Acquisition length per code
  function automatic logic [4:0] sacs_acq_tads(input logic [2:0] code);
    case (code)
      3'h0: sacs_acq_tads = 5'h00;
      3'h1: sacs_acq_tads = 5'h02;
      3'h2: sacs_acq_tads = 5'h04;
      3'h3: sacs_acq_tads = 5'h06;
      3'h4: sacs_acq_tads = 5'h08;
      3'h5: sacs_acq_tads = 5'h0c;
      3'h6: sacs_acq_tads = 5'h10;
      default: sacs_acq_tads = 5'h14;
    endcase
  endfunction

  // Divider terminal count (divisor minus one) per code
  function automatic logic [5:0] sacs_div_last(input logic [2:0] code);
    case (code)
      3'h0: sacs_div_last = 6'h01;
      3'h1: sacs_div_last = 6'h07;
      3'h2: sacs_div_last = 6'h1f;
      3'h4: sacs_div_last = 6'h03;
      3'h5: sacs_div_last = 6'h0f;
      3'h6: sacs_div_last = 6'h3f;
      default: sacs_div_last = 6'h3f;
    endcase
  endfunction

endpackage

// ---- sacs_core_properties.sv ----
`timescale 1ns/1ps
module sacs_core_properties
  import sacs_pkg::*;
#(
  parameter int INSTR_CYCLES = sacs_pkg::INSTR_CLKS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [sacs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // System side
  input wire logic sleep_mode,
  input wire logic converter_interrupt_enable,
  input wire logic special_event,
  input wire logic converter_interrupt_flag,
  input wire logic wake_request,
  input wire logic timer_counter_reset,
  // Analog side
  input wire logic analog_power,
  input wire logic sample_connect,
  input wire logic array_discharge,
  input wire logic [3:0] channel_select_field,
  input wire logic channel_valid,
  input wire logic pref_ext_sel,
  input wire logic pref_fvr_sel
);
  // All checks share the one system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_disable_stops: assert property (
    reg_wr && reg_addr == OFF_CTRL0 && !reg_wdata[0] |=> !analog_power && !sample_connect)
    else $error("converter still active after disable");
  a_sample_discharge: assert property (
    $fell(sample_connect) && analog_power |-> array_discharge)
    else $error("array not discharged after sampling");
  // Discharge held two clocks after completion, bounded return to sampling
  a_wait_discharge: assert property (
    $rose(converter_interrupt_flag) && analog_power |-> array_discharge[*2] ##[1:300] sample_connect)
    else $error("inter-conversion wait broken");
  a_ctrl0_upper: assert property (
    reg_rd && reg_addr == OFF_CTRL0 |=> reg_rdata[7:6] == 2'h0)
    else $error("control 0 upper bits not zero");
  a_ctrl1_upper: assert property (
    reg_rd && reg_addr == OFF_CTRL1 |=> reg_rdata[7:4] == 4'h0)
    else $error("reference register upper bits not zero");
  a_channel_decode: assert property (
    channel_valid == (channel_select_field inside {[4'h3:4'hb], 4'he, 4'hf}))
    else $error("channel decode wrong");
  a_ref_exclusive: assert property (
    pref_fvr_sel |-> !pref_ext_sel)
    else $error("two positive references at once");
  a_wake_cause: assert property (
    wake_request |-> converter_interrupt_flag && sleep_mode && converter_interrupt_enable)
    else $error("wake without completion in sleep");
  a_timer_pulse: assert property (
    timer_counter_reset |-> $past(special_event) ##1 !timer_counter_reset)
    else $error("timer reset pulse wrong");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> !analog_power && !converter_interrupt_flag && channel_select_field == 4'h0)
    else $error("state not cleared by reset");

  c_complete: cover property ($rose(converter_interrupt_flag));
  c_wake: cover property (wake_request);
  c_trigger: cover property (timer_counter_reset);
endmodule

bind sacs_core sacs_core_properties #(.INSTR_CYCLES(INSTR_CYCLES)) u_props (
  .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
  .converter_interrupt_enable(converter_interrupt_enable), .special_event(special_event),
  .converter_interrupt_flag(converter_interrupt_flag), .wake_request(wake_request),
  .timer_counter_reset(timer_counter_reset), .analog_power(analog_power),
  .sample_connect(sample_connect), .array_discharge(array_discharge),
  .channel_select_field(channel_select_field), .channel_valid(channel_valid),
  .pref_ext_sel(pref_ext_sel), .pref_fvr_sel(pref_fvr_sel)
);

// ---- sacs_analog_model.sv ----
`timescale 1ns/1ps
module sacs_analog_model (
  // Controls from the sequencer
  input wire logic analog_power,
  input wire logic [9:0] sar_trial,
  // Level on the selected input, in codes
  input wire logic [9:0] input_level,
  // Comparator and internal oscillator
  output logic comparator_pin,
  output logic rc_clk_pin
);
  logic osc = 1'b0;
  // Oscillator period 1.7 us, unrelated to the system clock
  always #850 osc = ~osc;
  assign rc_clk_pin = osc;
  // Unpowered comparator toggles so a stale decision is never mistaken for a real one
  assign comparator_pin = analog_power ? (input_level >= sar_trial) : osc;
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import sacs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_mode = 1'b0;
  logic irq_en = 1'b0;
  logic special_event = 1'b0;
  logic flag, wake_request, timer_counter_reset, rc_clk_pin, comparator_pin;
  logic analog_power, sample_connect, array_discharge, channel_valid, pref_ext_sel, pref_fvr_sel, nref_ext_sel;
  logic [9:0] sar_trial;
  logic [9:0] input_level = 10'h000;
  logic [3:0] chs;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  // Clock and cycle count
  always #50 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  sacs_core u_sacs_core (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_mode(sleep_mode),
    .converter_interrupt_enable(irq_en), .special_event(special_event),
    .converter_interrupt_flag(flag), .wake_request(wake_request), .timer_counter_reset(timer_counter_reset),
    .rc_clk_pin(rc_clk_pin), .comparator_pin(comparator_pin), .analog_power(analog_power),
    .sample_connect(sample_connect), .array_discharge(array_discharge), .sar_trial(sar_trial),
    .channel_select_field(chs), .channel_valid(channel_valid), .pref_ext_sel(pref_ext_sel),
    .pref_fvr_sel(pref_fvr_sel), .nref_ext_sel(nref_ext_sel));
  sacs_analog_model u_sacs_analog_model (.analog_power(analog_power), .sar_trial(sar_trial),
    .input_level(input_level), .comparator_pin(comparator_pin), .rc_clk_pin(rc_clk_pin));

  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus cycles: strobe for one cycle, read data taken in the following cycle
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  // Start from idle sampling; go must read back at once
  task automatic start(input logic [7:0] c2, input logic [9:0] lvl);
    repeat (100) @(posedge clk);
    wr(OFF_CTRL2, c2);
    input_level <= lvl;
    wr(OFF_CTRL0, 8'h0f);
    rdchk(OFF_CTRL0, 8'h0f);
  endtask
  // Poll go under a bound; a hang ends the run
  task automatic wait_done(output int dt);
    logic [7:0] v;
    int t0;
    t0 = cyc;
    v = 8'h02;
    for (int i = 0; i < 2000 && v[1] === 1'b1; i++) begin
      rd(OFF_CTRL0, v);
    end
    dt = cyc - t0;
    if (v[1] !== 1'b0) begin
      n_errors++;
      report_and_stop();
    end
  endtask

  initial begin
    logic [7:0] v;
    int d0;
    int d1;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 8; a++) begin
      rdchk(3'(a), 8'h00);
    end
    // Reference decodes, all codes
    for (int c = 0; c < 16; c++) begin
      wr(OFF_CTRL1, 8'hf0 | 8'(c));
      rdchk(OFF_CTRL1, 8'(c));
      chk({5'h00, pref_ext_sel, pref_fvr_sel, nref_ext_sel}, {5'h00, c[3:2] == 2'h1, c[3:2] == 2'h2, c[1:0] == 2'h1});
    end
    wr(OFF_CTRL2, 8'hff);
    rdchk(OFF_CTRL2, 8'hbf);
    // Channel codes, reserved ones included
    for (int c = 0; c < 16; c++) begin
      wr(OFF_CTRL0, 8'hc1 | 8'(c << 2));
      rdchk(OFF_CTRL0, 8'h01 | 8'(c << 2));
      chk({7'h00, channel_valid}, {7'h00, (c >= 3 && c <= 11) || c >= 14});
    end
    // Go inside the enabling write is not honoured
    wr(OFF_CTRL0, 8'h00);
    wr(OFF_CTRL0, 8'h0f);
    rdchk(OFF_CTRL0, 8'h0d);
    chk({7'h00, analog_power}, 8'h01);
    // Right justified, no acquisition, divide by 32
    start(8'h82, 10'h2aa);
    wait_done(d0);
    chk({7'h00, flag}, 8'h01);
    rdchk(OFF_RESH, 8'h02);
    rdchk(OFF_RESL, 8'haa);
    chk({7'h00, d0 >= 320 && d0 <= 360}, 8'h01);
    wr(OFF_STAT, 8'h01);
    rdchk(OFF_STAT, 8'h00);
    // Left justified with four periods of acquisition
    start(8'h12, 10'h2aa);
    wait_done(d1);
    rdchk(OFF_RESH, 8'haa);
    rdchk(OFF_RESL, 8'h80);
    chk({7'h00, d1 - d0 >= 97 && d1 - d0 <= 160}, 8'h01);
    // Abort mid-conversion: undecided bits copy the last one
    start(8'h82, 10'h3ff);
    repeat (150) @(posedge clk);
    wr(OFF_CTRL0, 8'h0d);
    rdchk(OFF_CTRL0, 8'h0d);
    rdchk(OFF_RESH, 8'h03);
    rdchk(OFF_RESL, 8'hff);
    // Sleep on a divided clock aborts and powers down
    start(8'h82, 10'h100);
    repeat (100) @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(OFF_CTRL0, 8'h0d);
    rd(OFF_STAT, v);
    chk({7'h00, v[1]}, 8'h01);
    chk({7'h00, analog_power}, 8'h00);
    sleep_mode <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({7'h00, analog_power}, 8'h01);
    // Oscillator clock converts through sleep and wakes
    // RC clock chosen for sleep conversion
    // clock selection left untouched until done
    irq_en <= 1'b1;
    start(8'h83, 10'h155);
    sleep_mode <= 1'b1;
    for (int i = 0; i < 3000 && wake_request !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({7'h00, wake_request}, 8'h01);
    // Leave sleep only after the wake pulse has been sampled
    @(posedge clk);
    sleep_mode <= 1'b0;
    irq_en <= 1'b0;
    rdchk(OFF_RESH, 8'h01);
    rdchk(OFF_RESL, 8'h55);
    wr(OFF_STAT, 8'h01);
    // Hardware trigger
    repeat (100) @(posedge clk);
    wr(OFF_CTRL2, 8'h82);
    @(posedge clk);
    special_event <= 1'b1;
    @(posedge clk);
    special_event <= 1'b0;
    #1 chk({7'h00, timer_counter_reset}, 8'h01);
    rdchk(OFF_CTRL0, 8'h0f);
    wait_done(d0);
    // Disable in the start delay with go set, then reset mid-conversion
    start(8'h82, 10'h2aa);
    wr(OFF_CTRL0, 8'h0c);
    rdchk(OFF_CTRL0, 8'h0c);
    wr(OFF_CTRL0, 8'h0d);
    start(8'h82, 10'h2aa);
    repeat (50) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(OFF_CTRL0, 8'h00);
    rdchk(OFF_RESL, 8'h00);
    report_and_stop();
  end
endmodule
